// ### hw/tpdb_params.svh
/*
  Offsets, field positions, reset values and timing figures of the
  timer protection, dead-time and DMA burst register bank.
  Assumes a byte-addressed register port with 32-bit words.
*/
`ifndef TPDB_PARAMS_SVH
`define TPDB_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TPDB_OFF_CTL0 8'h00
`define TPDB_OFF_CTL1 8'h04
`define TPDB_OFF_CHCTL 8'h18
`define TPDB_OFF_CHCTL2 8'h20
`define TPDB_OFF_CHVAL0 8'h34
`define TPDB_OFF_BDP 8'h44
`define TPDB_OFF_BURST_CFG 8'h48
`define TPDB_OFF_BURST_BUF 8'h4C
`define TPDB_OFF_CFG 8'hFC

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TPDB_CLKDIV_LSB 8
`define TPDB_BLEN_LSB 8
`define TPDB_CHAN_NUM 4
`define TPDB_RST_WORD 32'h0000_0000
`define TPDB_RST_DT 8'h00
`define TPDB_RST_LEVEL 2'h0
`define TPDB_BURST_MAX 5'h11

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TPDB_CLK_PERIOD_NS 20
`define TPDB_DIV_MAX_SHIFT 2'h2

`endif

// ### hw/tpdb_pkg.sv
/*
  Types of the timer protection, dead-time and DMA burst bank.
  Assumes the constants header is compiled alongside it.
*/
package tpdb_pkg;

  // Protection levels, from no lock to the strongest lock.
  typedef enum logic [1:0] {
    TPDB_LVL_OFF,
    TPDB_LVL_1,
    TPDB_LVL_2,
    TPDB_LVL_3
  } tpdb_level_t;

  // Break, dead-time and protection register contents.
  typedef struct packed {
    logic primary_output_enable;
    logic auto_output_enable;
    logic break_polarity;
    logic break_enable;
    logic run_offstate_enable;
    logic idle_offstate_enable;
    tpdb_level_t protect_level;
    logic [7:0] dead_time_code;
  } tpdb_bdp_t;

  // Per-channel compare control byte.
  typedef struct packed {
    logic resv;
    logic [2:0] compare_output_mode;
    logic compare_shadow_enable;
    logic resv2;
    logic [1:0] mode_select;
  } tpdb_chan_t;

endpackage

// ### hw/tpdb_regs.sv
/*
  Register bank of an advanced timer: write protection levels, the
  dead-time code and its decoded length, the DMA burst window and the
  compare write filter.  Assumes a single-cycle register port on CLOCK;
  counting, compare and break logic sit outside and read the outputs.
*/
// Operation
// - Level 1 locks idle-state bits, break enable, polarity, auto enable, dead time.
// - Level 2 adds output channel polarities and run/idle off-state enables.
// - Level 3 adds compare mode and shadow enable of output channels.
// - Protection level is writable once; first write to the break/dead-time register locks it.
// - Dead time: 0xx gives code ticks; 10x gives (64+low6)*2.
// - Dead time: 110 gives (32+low5)*8; 111 gives (32+low5)*16.
// - Dead-time clock period follows the two-bit clock division field.
// - Dead-time code is writable only at protection level zero.
// - Burst covers burst length field plus one registers, field 0 to 17; the code does not limit the 5-bit field, so values up to 31 are taken.
// - Burst start picks the first register; each later access adds four.
// - Buffer access goes to start plus four times the transfer index.
// - Buffer carries 16 data bits; upper bits are reserved.
// - With the filter set, equal compare value writes are dropped.
// - Idle output select with both enables clear disables outputs.
`timescale 1ns/1ns
`include "tpdb_params.svh"

module tpdb_regs (
  input wire logic CLOCK, // System clock, 50 MHz.
  input wire logic RESET_N, // Asynchronous reset, active low.
  input wire logic CE, // Clock enable; low freezes all state.
  input wire logic [7:0] ADDR, // Register byte address.
  input wire logic [31:0] WDATA, // Write data.
  input wire logic WR, // Write strobe.
  input wire logic RD, // Read strobe.
  output logic [31:0] RDATA, // Read data, one cycle after RD.
  output tpdb_pkg::tpdb_bdp_t BREAK_CFG, // Break and dead-time setup.
  output logic [1:0] CLOCK_DIVISION, // Dead-time clock division.
  output logic [9:0] DEAD_TIME_VALUE, // Dead time in dead-time ticks.
  output logic [11:0] DEAD_TIME_CYCLES, // Dead time in CLOCK cycles.
  output logic [4:0] BURST_INDEX, // Current burst transfer index.
  output logic OUTPUT_DISABLE // Channel outputs forced off.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tpdb_pkg::tpdb_bdp_t bdp;
  tpdb_pkg::tpdb_chan_t chan [`TPDB_CHAN_NUM];
  logic level_written;
  logic [1:0] clock_division;
  logic [7:0] idle_bits;
  logic [15:0] chctl2;
  logic [15:0] compare_value [`TPDB_CHAN_NUM];
  logic [4:0] burst_length;
  logic [4:0] burst_start;
  logic [4:0] burst_idx;
  logic same_value_write_filter;
  logic idle_output_select;
  logic [31:0] rdata_mux;

  // ----------------------------------------------------------------
  // Burst redirection and address decode
  // ----------------------------------------------------------------

  // A buffer access is steered to start plus four times the index.
  wire hit_buf = (ADDR == `TPDB_OFF_BURST_BUF);
  wire [5:0] tgt_word = {1'b0, burst_start} + {1'b0, burst_idx};
  wire [7:0] tgt_addr = {tgt_word, 2'b00};
  wire [7:0] eff_addr = hit_buf ? tgt_addr : ADDR;
  wire [31:0] eff_wdata = hit_buf ? {16'h0000, WDATA[15:0]} : WDATA;
  wire acc_buf = CE && hit_buf && (WR || RD);
  // A burst that points back at the buffer itself reaches nothing.
  wire loop_ok = !(hit_buf && tgt_addr == `TPDB_OFF_BURST_BUF);
  wire wr_ok = CE && WR && loop_ok;

  wire sel_ctl0 = (eff_addr == `TPDB_OFF_CTL0);
  wire sel_ctl1 = (eff_addr == `TPDB_OFF_CTL1);
  wire sel_chctl = (eff_addr == `TPDB_OFF_CHCTL);
  wire sel_chctl2 = (eff_addr == `TPDB_OFF_CHCTL2);
  wire sel_bdp = (eff_addr == `TPDB_OFF_BDP);
  wire sel_burst_cfg = (eff_addr == `TPDB_OFF_BURST_CFG);
  wire sel_cfg = (eff_addr == `TPDB_OFF_CFG);

  // Protection level compares.
  wire lvl_ge1 = (bdp.protect_level != tpdb_pkg::TPDB_LVL_OFF);
  wire lvl_ge2 = bdp.protect_level[1];
  wire lvl_ge3 = (bdp.protect_level == tpdb_pkg::TPDB_LVL_3);

  // ----------------------------------------------------------------
  // Break, dead-time and protection register
  // ----------------------------------------------------------------

  // Each field keeps its value when its lock is in force.
  wire [31:0] wd = eff_wdata;
  wire next_out_en = wd[15];
  wire next_auto_en = lvl_ge1 ? bdp.auto_output_enable : wd[14];
  wire next_brk_pol = lvl_ge1 ? bdp.break_polarity : wd[13];
  wire next_brk_en = lvl_ge1 ? bdp.break_enable : wd[12];
  wire next_run_off = lvl_ge2 ? bdp.run_offstate_enable : wd[11];
  wire next_idle_off = lvl_ge2 ? bdp.idle_offstate_enable : wd[10];
  wire [1:0] next_level = level_written ? bdp.protect_level : wd[9:8];
  wire [7:0] next_dt = lvl_ge1 ? bdp.dead_time_code : wd[7:0];

  // Register update; the first write to this register locks the level.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      bdp <= '0;
      level_written <= 1'b0;
    end else if (wr_ok && sel_bdp) begin
      bdp <= {next_out_en, next_auto_en, next_brk_pol, next_brk_en, next_run_off,
              next_idle_off, tpdb_pkg::tpdb_level_t'(next_level), next_dt};
      level_written <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control, idle-state and channel registers
  // ----------------------------------------------------------------

  // Clock division and idle-state bits; idle bits lock from level 1.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      clock_division <= 2'h0;
      idle_bits <= 8'h00;
    end else if (wr_ok) begin
      if (sel_ctl0) begin
        clock_division <= wd[`TPDB_CLKDIV_LSB +: 2];
      end
      if (sel_ctl1 && !lvl_ge1) begin
        idle_bits <= wd[7:0];
      end
    end
  end

  // Per-channel compare control, polarity and compare value.
  genvar gi;
  generate
    for (gi = 0; gi < `TPDB_CHAN_NUM; gi++) begin : g_chan
      wire is_out = (chan[gi].mode_select == 2'h0);
      wire [7:0] cbyte = wd[8*gi +: 8];
      wire lock_cmp = lvl_ge3 && is_out;
      wire lock_pol = lvl_ge2 && is_out;
      wire [3:0] nib = wd[4*gi +: 4];
      wire [3:0] old = chctl2[4*gi +: 4];
      wire [3:0] next_nib = lock_pol ? {old[3], nib[2], old[1], nib[0]} : nib;
      wire [7:0] hit_off = 8'(`TPDB_OFF_CHVAL0 + 4 * gi);
      wire sel_val = (eff_addr == hit_off);
      wire same = (wd[15:0] == compare_value[gi]);
      wire drop = same_value_write_filter && same;

      always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
          chan[gi] <= '0;
        end else if (wr_ok && sel_chctl) begin
          chan[gi].mode_select <= cbyte[1:0];
          if (!lock_cmp) begin
            chan[gi].compare_shadow_enable <= cbyte[3];
            chan[gi].compare_output_mode <= cbyte[6:4];
          end
        end
      end

      always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
          chctl2[4*gi +: 4] <= 4'h0;
        end else if (wr_ok && sel_chctl2) begin
          chctl2[4*gi +: 4] <= next_nib;
        end
      end

      always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
          compare_value[gi] <= 16'h0000;
        end else if (wr_ok && sel_val && !drop) begin
          compare_value[gi] <= wd[15:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // DMA burst and configuration registers
  // ----------------------------------------------------------------

  // Burst setup and filter/idle configuration.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      burst_length <= 5'h00;
      burst_start <= 5'h00;
      same_value_write_filter <= 1'b0;
      idle_output_select <= 1'b0;
    end else if (wr_ok) begin
      if (sel_burst_cfg) begin
        burst_length <= wd[`TPDB_BLEN_LSB +: 5];
        burst_start <= wd[4:0];
      end
      if (sel_cfg) begin
        same_value_write_filter <= wd[1];
        idle_output_select <= wd[0];
      end
    end
  end

  // Transfer index steps per buffer access and wraps after the last.
  wire idx_last = (burst_idx >= burst_length);
  wire [4:0] next_idx = idx_last ? 5'h00 : burst_idx + 5'h01;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      burst_idx <= 5'h00;
    end else if (acc_buf) begin
      burst_idx <= next_idx;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Read selection; buffer reads return only the low 16 bits.
  always_comb begin
    rdata_mux = 32'h0000_0000;
    if (loop_ok) begin
      if (sel_ctl0) rdata_mux = {22'h0, clock_division, 8'h00};
      if (sel_ctl1) rdata_mux = {24'h0, idle_bits};
      if (sel_chctl) rdata_mux = {chan[3], chan[2], chan[1], chan[0]};
      if (sel_chctl2) rdata_mux = {16'h0, chctl2};
      if (sel_bdp) rdata_mux = {16'h0, bdp};
      if (sel_burst_cfg) rdata_mux = {19'h0, burst_length, 3'h0, burst_start};
      if (sel_cfg) rdata_mux = {30'h0, same_value_write_filter, idle_output_select};
      for (int i = 0; i < `TPDB_CHAN_NUM; i++) begin
        if (eff_addr == 8'(`TPDB_OFF_CHVAL0 + 4 * i)) rdata_mux = {16'h0, compare_value[i]};
      end
      if (hit_buf) rdata_mux[31:16] = 16'h0000;
    end
  end

  // Read data stand for the single cycle after the strobe.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 32'h0000_0000;
    end else if (CE) begin
      RDATA <= RD ? rdata_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Dead-time decode and output control
  // ----------------------------------------------------------------

  // Code to ticks of the dead-time clock.
  wire [7:0] dtc = bdp.dead_time_code;
  wire [9:0] dt_lin = {2'b00, dtc};
  wire [9:0] dt_x2 = {2'b00, 1'b1, dtc[5:0], 1'b0};
  wire [9:0] dt_x8 = {1'b0, 1'b1, dtc[4:0], 3'b000};
  wire [9:0] dt_x16 = {1'b1, dtc[4:0], 4'b0000};
  assign DEAD_TIME_VALUE = !dtc[7] ? dt_lin : !dtc[6] ? dt_x2 : !dtc[5] ? dt_x8 : dt_x16;

  // Ticks to CLOCK cycles; the reserved division code acts as divide by four.
  wire [1:0] dt_shift = (clock_division > `TPDB_DIV_MAX_SHIFT) ? `TPDB_DIV_MAX_SHIFT
                        : clock_division;
  assign DEAD_TIME_CYCLES = {2'b00, DEAD_TIME_VALUE} << dt_shift;

  // Outputs forced off in idle with no off-state.
  assign OUTPUT_DISABLE = idle_output_select && !bdp.primary_output_enable
                          && !bdp.idle_offstate_enable;
  assign BREAK_CFG = bdp;
  assign CLOCK_DIVISION = clock_division;
  assign BURST_INDEX = burst_idx;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  property p_protect_level_once;
    (level_written && wr_ok && sel_bdp) |=> $stable(bdp.protect_level);
  endproperty
  a_protect_level_once: assert property (p_protect_level_once) else $error("protect level changed twice");

  property p_dt_lock;
    (lvl_ge1 && wr_ok && sel_bdp) |=> $stable(bdp.dead_time_code) && $stable(bdp.break_enable);
  endproperty
  a_dt_lock: assert property (p_dt_lock) else $error("dead time written while locked");

  property p_idle_lock;
    (lvl_ge1 && wr_ok && sel_ctl1) |=> $stable(idle_bits);
  endproperty
  a_idle_lock: assert property (p_idle_lock) else $error("idle bits written while locked");

  property p_offstate_lock;
    (lvl_ge2 && wr_ok && sel_bdp) |=> $stable(bdp.run_offstate_enable)
      && $stable(bdp.idle_offstate_enable);
  endproperty
  a_offstate_lock: assert property (p_offstate_lock) else $error("off-state bit changed");

  property p_mode_lock;
    (lvl_ge3 && g_chan[1].is_out && wr_ok && sel_chctl) |=> $stable(chan[1].compare_output_mode);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("compare mode changed while locked");

  property p_burst_wrap;
    (acc_buf && burst_idx == burst_length) |=> (burst_idx == 5'h00);
  endproperty
  a_burst_wrap: assert property (p_burst_wrap) else $error("burst index did not wrap");

  property p_burst_step;
    (acc_buf && burst_idx < burst_length) |=> (burst_idx == $past(burst_idx) + 5'h01);
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst index did not step");

  property p_dt_decode;
    (dtc[7:5] == 3'b111) |-> (DEAD_TIME_VALUE == (10'd32 + {5'h0, dtc[4:0]}) * 10'd16);
  endproperty
  a_dt_decode: assert property (p_dt_decode) else $error("dead time decode wrong");

  property p_buf_upper;
    (CE && RD && hit_buf) |=> (RDATA[31:16] == 16'h0000);
  endproperty
  a_buf_upper: assert property (p_buf_upper) else $error("buffer upper bits not zero");

  property p_out_dis;
    (wr_ok && sel_cfg && wd[0] && !bdp.primary_output_enable && !bdp.idle_offstate_enable)
      |=> OUTPUT_DISABLE;
  endproperty
  a_out_dis: assert property (p_out_dis) else $error("output disable mismatch");

  c_burst_wrap: cover property (acc_buf && idx_last && burst_length != 5'h00);
  c_protect_level_lvl3: cover property (lvl_ge3 && wr_ok && sel_chctl);
  c_filter_drop: cover property (wr_ok && g_chan[0].sel_val && g_chan[0].drop);

endmodule // tpdb_regs

// ### dv/tpdb_dma_master.sv
/*
  Register-port master that stands in for the DMA controller or CPU.
  Assumes the bank samples strobes on the rising edge of clock.
*/
`timescale 1ns/1ns

module tpdb_dma_master (
  input wire logic clock, // Bank clock.
  input wire logic [31:0] rdata, // Read data from the bank.
  output logic [7:0] addr, // Byte address.
  output logic [31:0] wdata, // Write data.
  output logic wr, // Write strobe.
  output logic rd // Read strobe.
);
  // The bus starts idle with no strobe raised.
  initial begin
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'h0;
    rd = 1'h0;
  end

  // One-cycle write; released data is inverted so it is never reused.
  task automatic put_word(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
    wdata <= ~d;
    addr <= ~a;
    @(negedge clock);
  endtask

  // One-cycle read; the data is taken in the cycle after the strobe.
  task automatic get_word(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    addr <= ~a;
    @(negedge clock);
    d = rdata;
  endtask
endmodule // tpdb_dma_master

// ### dv/tpdb_regs_tb_top.sv
/*
  Self-checking bench of the timer protection, dead-time and burst bank.
  Assumes the DMA master model drives the register port.
*/
`timescale 1ns/1ns
`include "tpdb_params.svh"

module timer_protect_deadtime_dma_burst_tb_top;
  logic clock, reset_n, ce, wr, rd;
  logic [7:0] addr, code;
  logic [31:0] wdata, rdata, d;
  logic [15:0] v;
  logic [1:0] div;
  logic [9:0] dtv;
  logic [11:0] dtc;
  logic [4:0] bidx;
  logic odis;
  tpdb_pkg::tpdb_bdp_t brk;
  int checks, miscompares, seed, e, sh;
  logic [15:0] q[$];
  logic [7:0] codes [4] = '{8'h7F, 8'hBF, 8'hDF, 8'hFF};

  // Design and the bus master facing it.
  tpdb_regs i_dut (.CLOCK(clock), .RESET_N(reset_n), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BREAK_CFG(brk),
    .CLOCK_DIVISION(div), .DEAD_TIME_VALUE(dtv), .DEAD_TIME_CYCLES(dtc),
    .BURST_INDEX(bidx), .OUTPUT_DISABLE(odis));
  tpdb_dma_master i_dma (.clock(clock), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));

  // Free-running 50 MHz clock.
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  // Dead-time ticks worked out from the code classes.
  function automatic int ticks(input logic [7:0] c);
    if (!c[7]) return c;
    if (!c[6]) return 2 * (64 + c[5:0]);
    return (32 + c[4:0]) * (c[5] ? 16 : 8);
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    i_dma.get_word(a, r);
    chk(r, x, "read data");
  endtask

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    conclude;
  end

  // Main sequence of tests.
  initial begin
    reset_n = 1'h0;
    ce = 1'h1;
    seed = $urandom(43);
    repeat (3) @(posedge clock);
    reset_n <= 1'h1;
    rdchk(`TPDB_OFF_BDP, 32'h0);
    rdchk(`TPDB_OFF_BURST_CFG, 32'h0);
    rdchk(`TPDB_OFF_CFG, 32'h0);
    rdchk(8'h80, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      code = (i < 4) ? codes[i] : 8'($urandom);
      sh = (i % 4 == 3) ? 2 : i % 4;
      i_dma.put_word(`TPDB_OFF_CTL0, 32'(i % 4) << 8);
      i_dma.put_word(`TPDB_OFF_BDP, {24'h0, code});
      chk({22'h0, dtv}, 32'(ticks(code)), "ticks");
      chk({20'h0, dtc}, 32'(ticks(code)) << sh, "cycles");
      chk({30'h0, div}, 32'(i % 4), "division");
    end
    $display("dead time done");
    for (int j = 0; j < 8; j++) begin
      i_dma.put_word(`TPDB_OFF_CFG, 32'(j % 2));
      i_dma.put_word(`TPDB_OFF_BDP, 32'((j / 2) % 2) << 15 | 32'(j / 4) << 10);
      chk({31'h0, odis}, 32'(j == 1), "output disable");
    end
    $display("output select done");
    i_dma.put_word(`TPDB_OFF_CFG, 32'h2);
    rdchk(`TPDB_OFF_CFG, 32'h2);
    i_dma.put_word(`TPDB_OFF_CHVAL0, 32'h1234);
    i_dma.put_word(`TPDB_OFF_CHVAL0, 32'h1234);
    rdchk(`TPDB_OFF_CHVAL0, 32'h1234);
    i_dma.put_word(`TPDB_OFF_CHVAL0, 32'h5678);
    rdchk(`TPDB_OFF_CHVAL0, 32'h5678);
    @(posedge clock);
    ce <= 1'h0;
    i_dma.put_word(`TPDB_OFF_CHVAL0, 32'hAAAA);
    @(posedge clock);
    ce <= 1'h1;
    rdchk(`TPDB_OFF_CHVAL0, 32'h5678);
    i_dma.put_word(8'h80, 32'hFFFF_FFFF);
    rdchk(8'h80, 32'h0);
    $display("filter and port done");
    i_dma.put_word(`TPDB_OFF_BURST_CFG, 32'h30D);
    rdchk(`TPDB_OFF_BURST_CFG, 32'h30D);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      q.push_back(v);
      i_dma.put_word(`TPDB_OFF_BURST_BUF, {16'($urandom), v});
      chk({27'h0, bidx}, 32'((i + 1) % 4), "index");
    end
    for (int i = 0; i < 4; i++) rdchk(8'(52 + 4 * i), {16'h0, q[i]});
    for (int i = 0; i < 4; i++) rdchk(`TPDB_OFF_BURST_BUF, {16'h0, q[i]});
    i_dma.put_word(`TPDB_OFF_BURST_CFG, 32'h1100);
    for (int i = 0; i < 18; i++) begin
      i_dma.get_word(`TPDB_OFF_BURST_BUF, d);
      chk({27'h0, bidx}, 32'((i + 1) % 18), "long index");
    end
    // A burst aimed back at the buffer itself reaches nothing.
    i_dma.put_word(`TPDB_OFF_BURST_CFG, 32'h13);
    i_dma.put_word(`TPDB_OFF_BURST_BUF, 32'hBEEF);
    rdchk(`TPDB_OFF_BURST_BUF, 32'h0);
    chk({27'h0, bidx}, 32'h0, "self index");
    $display("burst done");
    for (int l = 0; l < 4; l++) begin
      @(posedge clock);
      reset_n <= 1'h0;
      repeat (3) @(posedge clock);
      reset_n <= 1'h1;
      i_dma.put_word(`TPDB_OFF_CHCTL, 32'h1);
      i_dma.put_word(`TPDB_OFF_BDP, 32'(l * 256 + 'h11));
      i_dma.put_word(`TPDB_OFF_BDP, 32'hFFFF);
      e = 'h8000 + l * 256 + ((l >= 1) ? 'h11 : 'h70FF) + ((l >= 2) ? 0 : 'hC00);
      chk({16'h0, brk}, 32'(e), "break config");
      i_dma.put_word(`TPDB_OFF_CTL1, 32'hFF);
      rdchk(`TPDB_OFF_CTL1, (l >= 1) ? 32'h0 : 32'hFF);
      i_dma.put_word(`TPDB_OFF_CHCTL2, 32'hFFFF);
      rdchk(`TPDB_OFF_CHCTL2, (l >= 2) ? 32'h555F : 32'hFFFF);
      i_dma.put_word(`TPDB_OFF_CHCTL, 32'h7878_7879);
      rdchk(`TPDB_OFF_CHCTL, (l >= 3) ? 32'h79 : 32'h7878_7879);
      $display("protection level %0d done", l);
    end
    conclude;
  end
endmodule // timer_protect_deadtime_dma_burst_tb_top
